// ==== src/pdt_pkg.sv ====
// Package for the modulator channel with dead band and event trigger.
// Assumes one 125 MHz clock; counts are in clock cycles.
package pdt_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_PERIOD    = 8'h04;
   localparam logic [7:0] OFF_CMP_A     = 8'h08;
   localparam logic [7:0] OFF_CMP_C     = 8'h0C;
   localparam logic [7:0] OFF_RED       = 8'h10;
   localparam logic [7:0] OFF_FED       = 8'h14;
   localparam logic [7:0] OFF_ACTION    = 8'h18;
   localparam logic [7:0] OFF_DBCTRL    = 8'h1C;
   localparam logic [7:0] OFF_STATUS    = 8'h20;
   localparam logic [7:0] OFF_MASK      = 8'h24;
   localparam logic [7:0] OFF_COUNTER   = 8'h28;
   localparam logic [7:0] OFF_XBAR      = 8'h2C;
   // Control fields
   localparam int CTRL_RUN_BIT   = 0;
   localparam int CTRL_GLOBAL_BIT = 1;
   // Status bits
   localparam int ST_LOOP_BIT = 0;
   localparam int ST_ZERO_BIT = 1;
   // Reset values
   localparam logic [15:0] PERIOD_RST = 16'h07D0;
   localparam logic [15:0] CMP_A_RST  = 16'h0000;
   localparam logic [15:0] CMP_C_RST  = 16'h0064;
   localparam logic [15:0] DELAY_RST  = 16'h0014;
   // Action: [1:0] up-match, [3:2] down-match; 01 low, 10 high, 00 none
   localparam logic [3:0]  ACTION_RST = 4'h9;
   // Dead-band control: [0] rise enable, [1] fall enable, [2] fall invert
   localparam logic [2:0]  DBCTRL_RST = 3'h7;
   localparam logic [1:0]  ACT_LOW    = 2'h1;
   localparam logic [1:0]  ACT_HIGH   = 2'h2;
   localparam int          XBAR_OUTS  = 32;
endpackage

// ==== src/pdt_channel.sv ====
// One modulator channel: up-down counter, action qualifier with shadow,
// dead band, event trigger, crossbar routing and an AHB-Lite slave.
// Assumes a single AHB-Lite master and synchronous inputs on ref_clk.
`timescale 1ns/1ps
module pdt_channel #(
   parameter int CNT_W = 16,
   parameter int TB_DIV = 1
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Global load shared by all channels
   input  wire logic        global_load_strobe,
   // Gate drive and events
   output logic             first_modulator_output,
   output logic             second_modulator_output,
   output logic             sync_out,
   output logic             control_loop_interrupt,
   output logic [31:0]      interrupt_crossbar_out,
   output logic             irq
);
   typedef enum logic {PDT_UP = 1'b0, PDT_DOWN = 1'b1} pdt_dir_t;

   // Bus address phase capture
   logic             wr_pend_r, wr_pend_nxt;
   logic [7:0]       addr_r, addr_nxt;
   // Software settings
   logic [1:0]       ctrl_r, ctrl_nxt;
   logic [CNT_W-1:0] period_r, period_nxt, cmp_a_r, cmp_a_nxt, cmp_c_r, cmp_c_nxt;
   logic [CNT_W-1:0] red_sh_r, red_sh_nxt, fed_sh_r, fed_sh_nxt;
   logic [3:0]       act_sh_r, act_sh_nxt;
   logic [2:0]       dbc_sh_r, dbc_sh_nxt;
   logic [1:0]       status_r, status_nxt, mask_r, mask_nxt;
   logic [4:0]       xsel_r, xsel_nxt;
   logic [31:0]      hrdata_nxt;
   // Core state
   logic [CNT_W-1:0] cnt_r, cnt_nxt, red_r, red_nxt, fed_r, fed_nxt;
   logic [CNT_W-1:0] rdly_r, rdly_nxt, fdly_r, fdly_nxt;
   logic [3:0]       act_r, act_nxt;
   logic [2:0]       dbc_r, dbc_nxt;
   pdt_dir_t         dir_r, dir_nxt;
   logic             pwa_r, pwa_nxt, rise_r, rise_nxt, fall_r, fall_nxt;
   logic             pwb_r, pwb_nxt, sync_r, sync_nxt, loop_r, loop_nxt;
   logic [31:0]      xbar_r, xbar_nxt;
   logic             irq_r, irq_nxt;
   logic [7:0]       div_r, div_nxt;
   logic             tb_en;
   logic             at_zero, at_period, loop_ev, wr_go;

   function automatic logic pdt_act_apply(input logic [1:0] act, input logic cur);
      pdt_act_apply = (act == pdt_pkg::ACT_HIGH) ? 1'b1 :
                      (act == pdt_pkg::ACT_LOW) ? 1'b0 : cur;
   endfunction

   assign tb_en     = (div_r == 8'(TB_DIV - 1));
   assign at_zero   = tb_en && (cnt_r == '0) && ctrl_r[pdt_pkg::CTRL_RUN_BIT];
   assign at_period = tb_en && (cnt_r == period_r) && ctrl_r[pdt_pkg::CTRL_RUN_BIT];
   assign loop_ev   = tb_en && ctrl_r[pdt_pkg::CTRL_RUN_BIT] && dir_r == PDT_UP
                      && cnt_r == cmp_c_r;
   assign wr_go     = wr_pend_r;

   // Bus and register file
   always_comb
   begin
      wr_pend_nxt = hsel && hready && htrans[1] && hwrite;
      addr_nxt    = (hsel && hready && htrans[1]) ? haddr[7:0] : addr_r;
      ctrl_nxt    = ctrl_r;
      period_nxt  = period_r;
      cmp_a_nxt   = cmp_a_r;
      cmp_c_nxt   = cmp_c_r;
      red_sh_nxt  = red_sh_r;
      fed_sh_nxt  = fed_sh_r;
      act_sh_nxt  = act_sh_r;
      dbc_sh_nxt  = dbc_sh_r;
      mask_nxt    = mask_r;
      xsel_nxt    = xsel_r;
      status_nxt  = status_r;
      if (wr_go)
      begin
         unique case (addr_r)
            pdt_pkg::OFF_CTRL:   ctrl_nxt   = hwdata[1:0];
            pdt_pkg::OFF_PERIOD: period_nxt = hwdata[CNT_W-1:0];
            pdt_pkg::OFF_CMP_A:  cmp_a_nxt  = hwdata[CNT_W-1:0];
            pdt_pkg::OFF_CMP_C:  cmp_c_nxt  = hwdata[CNT_W-1:0];
            pdt_pkg::OFF_RED:    red_sh_nxt = hwdata[CNT_W-1:0];
            pdt_pkg::OFF_FED:    fed_sh_nxt = hwdata[CNT_W-1:0];
            pdt_pkg::OFF_ACTION: act_sh_nxt = hwdata[3:0];
            pdt_pkg::OFF_DBCTRL: dbc_sh_nxt = hwdata[2:0];
            pdt_pkg::OFF_STATUS: status_nxt = status_r & ~hwdata[1:0];
            pdt_pkg::OFF_MASK:   mask_nxt   = hwdata[1:0];
            pdt_pkg::OFF_XBAR:   xsel_nxt   = hwdata[4:0];
            default:             ;
         endcase
      end
      // Set wins over a clear in the same cycle
      if (loop_ev)
         status_nxt[pdt_pkg::ST_LOOP_BIT] = 1'b1;
      if (at_zero)
         status_nxt[pdt_pkg::ST_ZERO_BIT] = 1'b1;
      irq_nxt = |(status_nxt & mask_nxt);
      hrdata_nxt = 32'h0000_0000;
      if (hsel && hready && htrans[1] && !hwrite)
      begin
         unique case (haddr[7:0])
            pdt_pkg::OFF_CTRL:    hrdata_nxt = {30'h0, ctrl_r};
            pdt_pkg::OFF_PERIOD:  hrdata_nxt = 32'(period_r);
            pdt_pkg::OFF_CMP_A:   hrdata_nxt = 32'(cmp_a_r);
            pdt_pkg::OFF_CMP_C:   hrdata_nxt = 32'(cmp_c_r);
            pdt_pkg::OFF_RED:     hrdata_nxt = 32'(red_sh_r);
            pdt_pkg::OFF_FED:     hrdata_nxt = 32'(fed_sh_r);
            pdt_pkg::OFF_ACTION:  hrdata_nxt = {28'h0, act_sh_r};
            pdt_pkg::OFF_DBCTRL:  hrdata_nxt = {29'h0, dbc_sh_r};
            pdt_pkg::OFF_STATUS:  hrdata_nxt = {30'h0, status_r};
            pdt_pkg::OFF_MASK:    hrdata_nxt = {30'h0, mask_r};
            pdt_pkg::OFF_COUNTER: hrdata_nxt = {15'h0, dir_r == PDT_DOWN, cnt_r};
            pdt_pkg::OFF_XBAR:    hrdata_nxt = {27'h0, xsel_r};
            default:              hrdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         wr_pend_r <= 1'b0;
         addr_r    <= 8'h00;
         ctrl_r    <= 2'h0;
         period_r  <= pdt_pkg::PERIOD_RST;
         cmp_a_r   <= pdt_pkg::CMP_A_RST;
         cmp_c_r   <= pdt_pkg::CMP_C_RST;
         red_sh_r  <= pdt_pkg::DELAY_RST;
         fed_sh_r  <= pdt_pkg::DELAY_RST;
         act_sh_r  <= pdt_pkg::ACTION_RST;
         dbc_sh_r  <= pdt_pkg::DBCTRL_RST;
         status_r  <= 2'h0;
         mask_r    <= 2'h0;
         xsel_r    <= 5'h00;
         irq_r     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_r <= wr_pend_nxt;
         addr_r    <= addr_nxt;
         ctrl_r    <= ctrl_nxt;
         period_r  <= period_nxt;
         cmp_a_r   <= cmp_a_nxt;
         cmp_c_r   <= cmp_c_nxt;
         red_sh_r  <= red_sh_nxt;
         fed_sh_r  <= fed_sh_nxt;
         act_sh_r  <= act_sh_nxt;
         dbc_sh_r  <= dbc_sh_nxt;
         status_r  <= status_nxt;
         mask_r    <= mask_nxt;
         xsel_r    <= xsel_nxt;
         irq_r     <= irq_nxt;
         hrdata    <= hrdata_nxt;
      end
   end

   // Zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq       = irq_r;

   // Time base, action qualifier, dead band, event trigger
   always_comb
   begin
      div_nxt  = tb_en ? 8'h00 : 8'(div_r + 8'h01);
      cnt_nxt  = cnt_r;
      dir_nxt  = dir_r;
      act_nxt  = act_r;
      red_nxt  = red_r;
      fed_nxt  = fed_r;
      dbc_nxt  = dbc_r;
      pwa_nxt  = pwa_r;
      rdly_nxt = rdly_r;
      fdly_nxt = fdly_r;
      rise_nxt = rise_r;
      fall_nxt = fall_r;
      if (tb_en && ctrl_r[pdt_pkg::CTRL_RUN_BIT])
      begin
         if (dir_r == PDT_UP)
         begin
            if (cnt_r >= period_r)
            begin
               dir_nxt = PDT_DOWN;
               cnt_nxt = CNT_W'(cnt_r - 1'b1);
            end
            else
               cnt_nxt = CNT_W'(cnt_r + 1'b1);
         end
         else if (cnt_r == '0)
         begin
            dir_nxt = PDT_UP;
            cnt_nxt = CNT_W'(1);
         end
         else
            cnt_nxt = CNT_W'(cnt_r - 1'b1);
         if (cnt_r == cmp_a_r)
            pwa_nxt = pdt_act_apply(dir_r == PDT_UP ? act_r[1:0] : act_r[3:2], pwa_r);
         // Delays stretch only the leading edge of each path
         if (pwa_r != rise_r)
         begin
            if (!pwa_r || rdly_r >= red_r || !dbc_r[0])
            begin
               rise_nxt = pwa_r;
               rdly_nxt = '0;
            end
            else
               rdly_nxt = CNT_W'(rdly_r + 1'b1);
         end
         else
            rdly_nxt = '0;
         if (pwa_r != fall_r)
         begin
            if (pwa_r || fdly_r >= fed_r || !dbc_r[1])
            begin
               fall_nxt = pwa_r;
               fdly_nxt = '0;
            end
            else
               fdly_nxt = CNT_W'(fdly_r + 1'b1);
         end
         else
            fdly_nxt = '0;
      end
      if (at_period)
         red_nxt = red_sh_r;
      if (at_zero)
      begin
         fed_nxt = fed_sh_r;
         dbc_nxt = dbc_sh_r;
      end
      if (ctrl_r[pdt_pkg::CTRL_GLOBAL_BIT] ? (global_load_strobe && at_zero) : at_zero)
         act_nxt = act_sh_r;
      // From the next fall value: both outputs leave one register stage,
      // otherwise the dead time would shrink by a cycle
      pwb_nxt  = dbc_r[2] ? ~fall_nxt : fall_nxt;
      sync_nxt = at_zero;
      loop_nxt = loop_ev;
      xbar_nxt = 32'h0000_0000;
      xbar_nxt[xsel_r] = loop_ev;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         div_r  <= 8'h00;
         cnt_r  <= '0;
         dir_r  <= PDT_UP;
         act_r  <= pdt_pkg::ACTION_RST;
         red_r  <= pdt_pkg::DELAY_RST;
         fed_r  <= pdt_pkg::DELAY_RST;
         dbc_r  <= pdt_pkg::DBCTRL_RST;
         pwa_r  <= 1'b0;
         rdly_r <= '0;
         fdly_r <= '0;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
         pwb_r  <= 1'b1;
         sync_r <= 1'b0;
         loop_r <= 1'b0;
         xbar_r <= 32'h0000_0000;
      end
      else
      begin
         div_r  <= div_nxt;
         cnt_r  <= cnt_nxt;
         dir_r  <= dir_nxt;
         act_r  <= act_nxt;
         red_r  <= red_nxt;
         fed_r  <= fed_nxt;
         dbc_r  <= dbc_nxt;
         pwa_r  <= pwa_nxt;
         rdly_r <= rdly_nxt;
         fdly_r <= fdly_nxt;
         rise_r <= rise_nxt;
         fall_r <= fall_nxt;
         pwb_r  <= pwb_nxt;
         sync_r <= sync_nxt;
         loop_r <= loop_nxt;
         xbar_r <= xbar_nxt;
      end
   end

   assign first_modulator_output  = rise_r;
   assign second_modulator_output = pwb_r;
   assign sync_out                = sync_r;
   assign control_loop_interrupt  = loop_r;
   assign interrupt_crossbar_out  = xbar_r;

   AST_LOOP_AT_CMP_C: assert property (@(posedge ref_clk) disable iff (!resetn)
      loop_ev |=> control_loop_interrupt && $past(cnt_r) == $past(cmp_c_r))
      else $error("loop event without compare C match");
   AST_LOOP_UP_ONLY: assert property (@(posedge ref_clk) disable iff (!resetn)
      control_loop_interrupt |-> $past(dir_r) == PDT_UP)
      else $error("loop event while counting down");
   AST_SYNC_ZERO: assert property (@(posedge ref_clk) disable iff (!resetn)
      at_zero |=> sync_out)
      else $error("no sync at zero");
   AST_RED_LOAD: assert property (@(posedge ref_clk) disable iff (!resetn)
      at_period |=> red_r == $past(red_sh_r))
      else $error("rising delay not loaded at period");
   AST_FED_LOAD: assert property (@(posedge ref_clk) disable iff (!resetn)
      at_zero |=> fed_r == $past(fed_sh_r) && dbc_r == $past(dbc_sh_r))
      else $error("falling delay not loaded at zero");
   AST_ACT_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
      !at_zero |=> $stable(act_r))
      else $error("action changed away from zero");
   AST_GLOBAL: assert property (@(posedge ref_clk) disable iff (!resetn)
      ctrl_r[pdt_pkg::CTRL_GLOBAL_BIT] && at_zero && !global_load_strobe
      |=> $stable(act_r))
      else $error("global load without strobe");
   AST_INTERRUPT_CROSSBAR_OUTPUT_ZERO: assert property (@(posedge ref_clk) disable iff (!resetn)
      loop_ev && xsel_r == 5'h00 |=> interrupt_crossbar_out == 32'h0000_0001)
      else $error("crossbar output zero not driven");
   AST_CNT_RANGE: assert property (@(posedge ref_clk) disable iff (!resetn)
      ctrl_r[pdt_pkg::CTRL_RUN_BIT] && cnt_r == period_r && tb_en && dir_r == PDT_UP
      |=> dir_r == PDT_DOWN)
      else $error("counter did not turn at period");
   AST_NO_OVERLAP: assert property (@(posedge ref_clk) disable iff (!resetn)
      dbc_r == pdt_pkg::DBCTRL_RST
      |-> !(first_modulator_output && second_modulator_output))
      else $error("both gate outputs high together");
endmodule

// ==== sim/pdt_gate_model.sv ====
// Gate driver pair model on the two modulator outputs.
// Assumes both outputs are registers on ref_clk; measures dead time in cycles.
`timescale 1ns/1ps
module pdt_gate_model (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Gate inputs
   input  wire logic        high_side,
   input  wire logic        low_side,
   // Observations
   output logic             overlap_seen,
   output logic [15:0]      rise_gap,
   output logic [15:0]      fall_gap
);
   logic        high_q;
   logic        low_q;
   logic [15:0] since_high_fall;
   logic [15:0] since_low_fall;

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         overlap_seen    <= 1'b0;
         rise_gap        <= 16'h0000;
         fall_gap        <= 16'h0000;
         high_q          <= 1'b0;
         low_q           <= 1'b1;
         since_high_fall <= 16'h0000;
         since_low_fall  <= 16'h0000;
      end
      else
      begin
         high_q          <= high_side;
         low_q           <= low_side;
         since_high_fall <= (high_q && !high_side) ? 16'h0001 : since_high_fall + 16'h0001;
         since_low_fall  <= (low_q && !low_side) ? 16'h0001 : since_low_fall + 16'h0001;
         // Both switches on shorts the bus leg
         if (high_side && low_side)
            overlap_seen <= 1'b1;
         if (!low_q && low_side)
            fall_gap <= since_high_fall;
         if (!high_q && high_side)
            rise_gap <= since_low_fall;
      end
   end
endmodule

// ==== sim/pwm_deadband_event_trigger_bench.sv ====
// Bench for one modulator channel: AHB-Lite register tasks and timed scenarios.
// Assumes hreadyout feeds hready and a 125 MHz ref_clk.
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pwm_deadband_event_trigger_bench;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        hsel = 1'b1;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic        global_load_strobe = 1'b0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        first_out;
   logic        second_out;
   logic        sync_out;
   logic        loop_irq;
   logic [31:0] xbar_out;
   logic        irq;
   logic        overlap_seen;
   logic [15:0] rise_gap;
   logic [15:0] fall_gap;
   logic [31:0] rd;
   int          miscompares = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          t0;
   logic [7:0]  rst_addr [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h30};
   logic [31:0] rst_exp [8] = '{32'h000007D0, 32'h0, 32'h00000064, 32'h00000014,
                                32'h00000014, 32'h00000009, 32'h00000007, 32'h0};

   always #4 ref_clk = ~ref_clk;

   pdt_channel dut (
      .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .global_load_strobe(global_load_strobe),
      .first_modulator_output(first_out), .second_modulator_output(second_out),
      .sync_out(sync_out), .control_loop_interrupt(loop_irq),
      .interrupt_crossbar_out(xbar_out), .irq(irq));

   pdt_gate_model gm (
      .ref_clk(ref_clk), .resetn(resetn), .high_side(first_out), .low_side(second_out),
      .overlap_seen(overlap_seen), .rise_gap(rise_gap), .fall_gap(fall_gap));

   task automatic give_verdict();
      if (miscompares == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Counted on the falling edge so waits at the rising edge see a settled count
   always @(negedge ref_clk)
   begin
      cycles++;
      // Ceiling well above the roughly 49500 cycles the scenarios need
      if (cycles == 95000)
      begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic ahb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                           output logic [31:0] data);
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h000000, addr};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      data = hrdata;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
      logic [31:0] unused;
      ahb_xfer(1'b1, addr, wd, unused);
   endtask

   // Waits for a sync pulse (which 0) or a loop interrupt pulse (which 1)
   task automatic wait_evt(input int which);
      for (int i = 0; i < 5000; i++)
      begin
         @(posedge ref_clk);
         if ((which == 0 ? sync_out : loop_irq) === 1'b1)
            return;
      end
      miscompares++;
      give_verdict();
   endtask

   initial
   begin
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      `CHECK_EQ(first_out, 1'b0)
      `CHECK_EQ(second_out, 1'b1)
      for (int i = 0; i < 8; i++)
      begin
         ahb_xfer(1'b0, rst_addr[i], 32'h0, rd);
         `CHECK_EQ(rd, rst_exp[i])
      end
      `CHECK_EQ(hresp, 1'b0)
      wr(pdt_pkg::OFF_CMP_A, 32'd1000);
      wr(pdt_pkg::OFF_MASK, 32'h0);
      wr(pdt_pkg::OFF_CTRL, 32'h1);
      wait_evt(0);
      wait_evt(0);
      t0 = cycles;
      wait_evt(0);
      `CHECK_EQ(cycles - t0, 4000)
      t0 = cycles;
      wait_evt(1);
      `CHECK_EQ(cycles - t0, 100)
      `CHECK_EQ(xbar_out, 32'h00000001)
      t0 = cycles;
      wait_evt(1);
      `CHECK_EQ(cycles - t0, 4000)
      `CHECK_EQ(fall_gap, 16'd20)
      `CHECK_EQ(rise_gap, 16'd20)
      `CHECK_EQ(overlap_seen, 1'b0)
      wait_evt(0);
      ahb_xfer(1'b0, pdt_pkg::OFF_COUNTER, 32'h0, rd);
      `CHECK_EQ(rd, 32'h00000002)
      repeat (1500) @(posedge ref_clk);
      `CHECK_EQ(first_out, 1'b0)
      `CHECK_EQ(second_out, 1'b1)
      // Interrupt: masked, unmasked, cleared
      ahb_xfer(1'b0, pdt_pkg::OFF_STATUS, 32'h0, rd);
      `CHECK_EQ(rd, 32'h00000003)
      `CHECK_EQ(irq, 1'b0)
      wr(pdt_pkg::OFF_MASK, 32'h1);
      repeat (2) @(posedge ref_clk);
      `CHECK_EQ(irq, 1'b1)
      wr(pdt_pkg::OFF_STATUS, 32'h1);
      repeat (2) @(posedge ref_clk);
      `CHECK_EQ(irq, 1'b0)
      wr(pdt_pkg::OFF_XBAR, 32'd31);
      wait_evt(1);
      `CHECK_EQ(xbar_out, 32'h80000000)
      // New delays through shadows
      wr(pdt_pkg::OFF_RED, 32'd40);
      wr(pdt_pkg::OFF_FED, 32'd10);
      repeat (3) wait_evt(0);
      `CHECK_EQ(rise_gap, 16'd40)
      `CHECK_EQ(fall_gap, 16'd10)
      // Global load: no transfer until the shared strobe is high at zero
      wr(pdt_pkg::OFF_CTRL, 32'h3);
      wr(pdt_pkg::OFF_ACTION, 32'h6);
      repeat (2) wait_evt(0);
      repeat (1500) @(posedge ref_clk);
      `CHECK_EQ(first_out, 1'b0)
      global_load_strobe <= 1'b1;
      repeat (2) wait_evt(0);
      repeat (1500) @(posedge ref_clk);
      `CHECK_EQ(first_out, 1'b1)
      `CHECK_EQ(second_out, 1'b0)
      `CHECK_EQ(overlap_seen, 1'b0)
      give_verdict();
   end
endmodule
